// ===== asq_host_ctrl.v
/*
  Host controller for a conversion sequencer and its sample store.
  Takes one operation at a time from the user port and carries it out
  as register reads and writes on the device port.
  Assumes the device read data is registered in the core clock domain.
*/
// Operation
// - Stop writes go zero, polls until clear.
// - Start writes one to go flag.
// - Stop and confirm before writing mode.
// - Single-pass selects mode one while stopped.
// - Recalibrate: save, stop, request, go, poll, restore.
// - Interrupt enable sets packet-done enable bit.
// - Interrupt disable clears packet-done enable bit.
// - Clear packet-done flag after handling packet.
// - Wait polls status while flag reads zero.
// - Query reports -1 if set, else 0.
`timescale 1ns/1ps
`include "asq_defs.vh"
module asq_host_ctrl (
  input  wire        i_core_clk,   // Core clock 125 MHz
  input  wire        i_rst_n,      // Async reset, active low
  input  wire        i_op_valid,   // Operation request
  input  wire [3:0]  i_op,         // Operation code
  output wire        o_op_ready,   // Ready for an operation
  output reg         o_op_done,    // Operation finished pulse
  output reg  [31:0] o_result,     // Query result or last status read
  output wire        o_dev_read,   // Device read strobe
  output wire        o_dev_write,  // Device write strobe
  output wire [6:0]  o_dev_addr,   // Device word address
  output wire [31:0] o_dev_wdata,  // Device write data
  input  wire [31:0] i_dev_rdata   // Device read data
);

  // ****************************************
  // States
  // ****************************************
  localparam [3:0] S_IDLE    = 4'h0;
  localparam [3:0] S_RD_CMD  = 4'h1;
  localparam [3:0] S_WR_STOP = 4'h2;
  localparam [3:0] S_POLL    = 4'h3;
  localparam [3:0] S_WR_MODE = 4'h4;
  localparam [3:0] S_WR_GO   = 4'h5;
  localparam [3:0] S_RD_IER  = 4'h6;
  localparam [3:0] S_WR_IER  = 4'h7;
  localparam [3:0] S_WR_ISR  = 4'h8;
  localparam [3:0] S_RD_ISR  = 4'h9;
  localparam [3:0] S_RESTORE = 4'ha;
  localparam [3:0] S_FINISH  = 4'hb;

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [3:0]  op_r;
  reg  [31:0] saved_cmd_r;
  reg  [31:0] saved_cmd_nxt;
  reg  [31:0] result_nxt;
  reg         issued_r;
  reg         recal_go_r;
  reg         req;
  reg         wr;
  reg  [6:0]  addr;
  reg  [31:0] wdata;
  wire        done;
  wire [31:0] rdata;
  wire        go_bit   = rdata[`ASQ_CMD_GO_BIT];
  wire        pkt_bit  = rdata[`ASQ_PKT_DONE_BIT];

  assign o_op_ready = (state_r == S_IDLE);

  asq_bus_port u_port (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_req       (req),
    .i_wr        (wr),
    .i_addr      (addr),
    .i_wdata     (wdata),
    .o_done      (done),
    .o_rdata     (rdata),
    .o_dev_read  (o_dev_read),
    .o_dev_write (o_dev_write),
    .o_dev_addr  (o_dev_addr),
    .o_dev_wdata (o_dev_wdata),
    .i_dev_rdata (i_dev_rdata)
  );

  // ****************************************
  // Access issue: one request at a time; a finished access lets the same state issue again
  // ****************************************
  always @* begin
    req   = 1'b0;
    wr    = 1'b0;
    addr  = `ASQ_CMD_ADDR;
    wdata = 32'h00000000;
    case (state_r)
      S_RD_CMD: begin
        req = ~issued_r;
      end
      S_WR_STOP: begin
        req = ~issued_r;
        wr  = 1'b1;
        // Keep the mode bits, drop the go flag
        wdata = saved_cmd_r & ~(32'h00000001 << `ASQ_CMD_GO_BIT);
      end
      S_POLL: begin
        req = ~issued_r;
      end
      S_WR_MODE: begin
        req = ~issued_r;
        wr  = 1'b1;
        // Go stays clear here; the device would drop the mode while running
        case (op_r)
          `ASQ_OP_MODE_SINGLE: wdata[`ASQ_CMD_MODE_MSB:`ASQ_CMD_MODE_LSB] = `ASQ_MODE_SINGLE;
          `ASQ_OP_MODE_CONT:   wdata[`ASQ_CMD_MODE_MSB:`ASQ_CMD_MODE_LSB] = `ASQ_MODE_CONT;
          default:             wdata[`ASQ_CMD_MODE_MSB:`ASQ_CMD_MODE_LSB] = `ASQ_MODE_RECAL;
        endcase
      end
      S_WR_GO: begin
        req = ~issued_r;
        wr  = 1'b1;
        wdata = saved_cmd_r | (32'h00000001 << `ASQ_CMD_GO_BIT);
        if (op_r == `ASQ_OP_RECAL)
          wdata = {28'h0000000, `ASQ_MODE_RECAL, 1'b1};
      end
      S_RD_IER: begin
        req  = ~issued_r;
        addr = `ASQ_IER_ADDR;
      end
      S_WR_IER: begin
        req   = ~issued_r;
        wr    = 1'b1;
        addr  = `ASQ_IER_ADDR;
        wdata = saved_cmd_r & ~(32'h00000001 << `ASQ_PKT_DONE_BIT);
        if (op_r == `ASQ_OP_IRQ_EN)
          wdata = saved_cmd_r | (32'h00000001 << `ASQ_PKT_DONE_BIT);
      end
      S_WR_ISR: begin
        req   = ~issued_r;
        wr    = 1'b1;
        addr  = `ASQ_ISR_ADDR;
        // Write-one-to-clear; other bits written zero are left alone
        wdata = 32'h00000001 << `ASQ_PKT_DONE_BIT;
      end
      S_RD_ISR: begin
        req  = ~issued_r;
        addr = `ASQ_ISR_ADDR;
      end
      S_RESTORE: begin
        req   = ~issued_r;
        wr    = 1'b1;
        wdata = saved_cmd_r;
      end
      default: begin
        req = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Sequence control
  // ****************************************
  always @* begin
    state_nxt     = state_r;
    saved_cmd_nxt = saved_cmd_r;
    result_nxt    = o_result;
    case (state_r)
      S_IDLE: begin
        if (i_op_valid) begin
          case (i_op)
            `ASQ_OP_STOP, `ASQ_OP_START, `ASQ_OP_RECAL,
            `ASQ_OP_MODE_SINGLE, `ASQ_OP_MODE_CONT: state_nxt = S_RD_CMD;
            `ASQ_OP_IRQ_EN, `ASQ_OP_IRQ_DIS:        state_nxt = S_RD_IER;
            `ASQ_OP_CLR_STATUS:                     state_nxt = S_WR_ISR;
            `ASQ_OP_WAIT_PKT, `ASQ_OP_QUERY:        state_nxt = S_RD_ISR;
            default:                                state_nxt = S_FINISH;
          endcase
        end
      end
      S_RD_CMD: begin
        if (done) begin
          saved_cmd_nxt = rdata;
          if (op_r == `ASQ_OP_START)
            state_nxt = S_WR_GO;
          else
            state_nxt = S_WR_STOP;
        end
      end
      S_WR_STOP: begin
        if (done)
          state_nxt = S_POLL;
      end
      S_POLL: begin
        // Go reads clear: either the stop has taken hold or the recalibration is over
        if (done && !go_bit) begin
          if (recal_go_r) begin
            state_nxt = S_RESTORE;
          end else begin
            case (op_r)
              `ASQ_OP_STOP:                        state_nxt = S_FINISH;
              `ASQ_OP_MODE_SINGLE, `ASQ_OP_MODE_CONT,
              `ASQ_OP_RECAL:                       state_nxt = S_WR_MODE;
              default:                             state_nxt = S_FINISH;
            endcase
          end
        end
      end
      S_WR_MODE: begin
        if (done) begin
          if (op_r == `ASQ_OP_RECAL)
            state_nxt = S_WR_GO;
          else
            state_nxt = S_FINISH;
        end
      end
      S_WR_GO: begin
        if (done) begin
          if (op_r == `ASQ_OP_RECAL) begin
            // Reuse the poll state; recal_go_r sends it on to the restore write
            state_nxt = S_POLL;
          end else begin
            state_nxt = S_FINISH;
          end
        end
      end
      S_RD_IER: begin
        if (done) begin
          saved_cmd_nxt = rdata;
          state_nxt     = S_WR_IER;
        end
      end
      S_WR_IER: begin
        if (done)
          state_nxt = S_FINISH;
      end
      S_WR_ISR: begin
        if (done)
          state_nxt = S_FINISH;
      end
      S_RD_ISR: begin
        if (done) begin
          if (op_r == `ASQ_OP_QUERY) begin
            result_nxt = pkt_bit ? 32'hffffffff : 32'h00000000;
            state_nxt  = S_FINISH;
          end else if (pkt_bit) begin
            result_nxt = rdata;
            state_nxt  = S_FINISH;
          end else begin
            state_nxt = S_RD_ISR;
          end
        end
      end
      S_RESTORE: begin
        if (done)
          state_nxt = S_FINISH;
      end
      S_FINISH: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // ****************************************
  // State and operation registers
  // ****************************************
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r     <= S_IDLE;
      op_r        <= `ASQ_OP_STOP;
      saved_cmd_r <= 32'h00000000;
      o_result    <= 32'h00000000;
      o_op_done   <= 1'b0;
      issued_r    <= 1'b0;
      recal_go_r  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      saved_cmd_r <= saved_cmd_nxt;
      o_result    <= result_nxt;
      // One pulse as the sequence reaches its last state
      o_op_done   <= (state_nxt == S_FINISH) && (state_r != S_FINISH);
      if (state_r == S_IDLE && i_op_valid)
        op_r <= i_op;
      // A finished access lets the same state issue again, which is how the poll loops repeat
      if (done)
        issued_r <= 1'b0;
      else if (req)
        issued_r <= 1'b1;
      // Marks the second poll of a recalibration, the one that waits for the device to drop go
      if (state_r == S_IDLE)
        recal_go_r <= 1'b0;
      else if (state_r == S_WR_GO && done && op_r == `ASQ_OP_RECAL)
        recal_go_r <= 1'b1;
    end
  end

endmodule // asq_host_ctrl

// ===== asq_defs.vh
/*
  Register map and command encodings for the conversion sequencer host controller.
  Assumes: word-addressed register port on the device, 32-bit data.
*/
`ifndef ASQ_DEFS_VH
`define ASQ_DEFS_VH

// ****************************************
// Sequencer command register
// ****************************************
`define ASQ_CMD_ADDR        7'h00
`define ASQ_CMD_GO_BIT      0
`define ASQ_CMD_MODE_LSB    1
`define ASQ_CMD_MODE_MSB    3
`define ASQ_MODE_CONT       3'h0
`define ASQ_MODE_SINGLE     3'h1
`define ASQ_MODE_RECAL      3'h7

// ****************************************
// Sample store registers
// ****************************************
`define ASQ_IER_ADDR        7'h40
`define ASQ_ISR_ADDR        7'h41
`define ASQ_PKT_DONE_BIT    0
`define ASQ_IER_RESET       32'h00000001

// ****************************************
// Host operations
// ****************************************
`define ASQ_OP_STOP         4'h0
`define ASQ_OP_START        4'h1
`define ASQ_OP_MODE_SINGLE  4'h2
`define ASQ_OP_MODE_CONT    4'h3
`define ASQ_OP_RECAL        4'h4
`define ASQ_OP_IRQ_EN       4'h5
`define ASQ_OP_IRQ_DIS      4'h6
`define ASQ_OP_CLR_STATUS   4'h7
`define ASQ_OP_WAIT_PKT     4'h8
`define ASQ_OP_QUERY        4'h9

`endif

// ===== asq_bus_port.v
/*
  Single register access engine: one read or write per request.
  Assumes the device answers reads one cycle after the strobe, writes take one cycle.
*/
`timescale 1ns/1ps
module asq_bus_port (
  input  wire        i_core_clk,   // Core clock
  input  wire        i_rst_n,      // Async reset, active low
  input  wire        i_req,        // Access request pulse
  input  wire        i_wr,         // 1 write, 0 read
  input  wire [6:0]  i_addr,       // Word address
  input  wire [31:0] i_wdata,      // Write data
  output reg         o_done,       // Access finished pulse
  output reg  [31:0] o_rdata,      // Read data
  output reg         o_dev_read,   // Device read strobe
  output reg         o_dev_write,  // Device write strobe
  output reg  [6:0]  o_dev_addr,   // Device address
  output reg  [31:0] o_dev_wdata,  // Device write data
  input  wire [31:0] i_dev_rdata   // Device read data
);
  reg rd_pend_r;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done      <= 1'b0;
      o_rdata     <= 32'h00000000;
      o_dev_read  <= 1'b0;
      o_dev_write <= 1'b0;
      o_dev_addr  <= 7'h00;
      o_dev_wdata <= 32'h00000000;
      rd_pend_r   <= 1'b0;
    end else begin
      o_done      <= 1'b0;
      o_dev_read  <= 1'b0;
      o_dev_write <= 1'b0;
      rd_pend_r   <= o_dev_read;
      if (i_req) begin
        o_dev_addr  <= i_addr;
        o_dev_wdata <= i_wdata;
        o_dev_read  <= ~i_wr;
        o_dev_write <= i_wr;
      end
      if (o_dev_write)
        o_done <= 1'b1;
      if (rd_pend_r) begin
        o_rdata <= i_dev_rdata;
        o_done  <= 1'b1;
      end
    end
  end
endmodule // asq_bus_port

// ===== asq_host_chk.sv
/* Checker of the host controller ports.
   Assumes reads return data one cycle after the strobe. */
`timescale 1ns/1ps
`include "asq_defs.vh"
module asq_host_chk (
  input wire logic        i_core_clk,  // Clock
  input wire logic        i_rst_n,     // Reset, active low
  input wire logic        i_op_valid,  // Op request
  input wire logic [3:0]  i_op,        // Op code
  input wire logic        o_op_ready,  // Ready
  input wire logic        o_op_done,   // Done pulse
  input wire logic [31:0] o_result,    // Result
  input wire logic        o_dev_read,  // Read strobe
  input wire logic        o_dev_write, // Write strobe
  input wire logic [6:0]  o_dev_addr,  // Address
  input wire logic [31:0] o_dev_wdata, // Write data
  input wire logic [31:0] i_dev_rdata  // Read data
);
  logic [3:0]  op_r;
  logic [6:0]  la_r, ra_r;
  logic [31:0] ld_r;
  logic [2:0]  md_r;
  logic        go_r, rp_r, isr_r;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ****************
  // Shadow of last write and go state; go counts as live until a poll reads it clear
  // ****************
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_r <= 4'h0; la_r <= 7'h7f; ra_r <= 7'h00; ld_r <= 32'h0; md_r <= 3'h0;
      go_r <= 1'b0; rp_r <= 1'b0; isr_r <= 1'b0;
    end else begin
      rp_r <= o_dev_read;
      ra_r <= o_dev_addr;
      if (i_op_valid && o_op_ready) begin
        op_r <= i_op; la_r <= 7'h7f; isr_r <= 1'b0;
      end
      if (o_dev_write) begin
        la_r <= o_dev_addr; ld_r <= o_dev_wdata;
        if (o_dev_addr == `ASQ_CMD_ADDR) begin
          md_r <= o_dev_wdata[3:1];
          if (o_dev_wdata[0]) go_r <= 1'b1;
        end
      end
      if (rp_r && ra_r == `ASQ_CMD_ADDR && !i_dev_rdata[0]) go_r <= 1'b0;
      if (rp_r && ra_r == `ASQ_ISR_ADDR) isr_r <= i_dev_rdata[0];
    end
  end
  sequence s_done(logic [3:0] op); o_op_done && op_r == op; endsequence
  property p_stop; s_done(`ASQ_OP_STOP) |-> !go_r && la_r == `ASQ_CMD_ADDR && !ld_r[0]; endproperty
  property p_start; s_done(`ASQ_OP_START) |-> la_r == `ASQ_CMD_ADDR && ld_r[0]; endproperty
  property p_mode; o_dev_write && o_dev_addr == `ASQ_CMD_ADDR && o_dev_wdata[3:1] != md_r |-> !go_r; endproperty
  property p_single; s_done(`ASQ_OP_MODE_SINGLE) |-> la_r == `ASQ_CMD_ADDR && ld_r[3:0] == 4'h2; endproperty
  property p_en; s_done(`ASQ_OP_IRQ_EN) |-> la_r == `ASQ_IER_ADDR && ld_r[0]; endproperty
  property p_dis; s_done(`ASQ_OP_IRQ_DIS) |-> la_r == `ASQ_IER_ADDR && !ld_r[0]; endproperty
  property p_clr; s_done(`ASQ_OP_CLR_STATUS) |-> la_r == `ASQ_ISR_ADDR && ld_r[0]; endproperty
  property p_wait; s_done(`ASQ_OP_WAIT_PKT) |-> isr_r; endproperty
  property p_query; s_done(`ASQ_OP_QUERY) |-> o_result == (isr_r ? 32'hffffffff : 32'h0); endproperty
  a_stop: assert property (p_stop) else $error("stop ended with go not confirmed clear");
  a_start: assert property (p_start) else $error("start did not set go");
  a_mode: assert property (p_mode) else $error("mode written while running");
  a_single: assert property (p_single) else $error("single mode write wrong");
  a_en: assert property (p_en) else $error("enable write wrong");
  a_dis: assert property (p_dis) else $error("disable write wrong");
  a_clr: assert property (p_clr) else $error("status clear write wrong");
  a_wait: assert property (p_wait) else $error("wait ended without flag");
  a_query: assert property (p_query) else $error("query result wrong");
endmodule // asq_host_chk
bind asq_host_ctrl asq_host_chk asq_host_chk_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_op_valid(i_op_valid), .i_op(i_op), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
  .o_result(o_result), .o_dev_read(o_dev_read), .o_dev_write(o_dev_write),
  .o_dev_addr(o_dev_addr), .o_dev_wdata(o_dev_wdata), .i_dev_rdata(i_dev_rdata));

// ===== asq_dev_model.sv
/* Model of the sequencer and sample store registers.
   Assumes one access per strobe; read data one cycle later. */
`timescale 1ns/1ps
module asq_dev_model #(parameter int STOP_LAT = 3, parameter int RECAL_LAT = 6) (
  input  wire logic        i_core_clk,  // Clock
  input  wire logic        i_rst_n,     // Reset, active low
  input  wire logic        i_rd,        // Read strobe
  input  wire logic        i_wr,        // Write strobe
  input  wire logic [6:0]  i_addr,      // Address
  input  wire logic [31:0] i_wdata,     // Write data
  output logic      [31:0] o_rdata,     // Read data
  input  wire logic        i_pkt,       // Packet stored
  output wire logic        o_irq        // Interrupt
);
  logic       go_r, ier_r, flag_r, stp_r;
  logic [2:0] mode_r;
  logic [7:0] cnt_r;
  int         n_recal;
  assign o_irq = flag_r & ier_r;
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      go_r <= 1'b0; ier_r <= 1'b1; flag_r <= 1'b0; stp_r <= 1'b0; mode_r <= 3'h0;
      cnt_r <= 8'h00; o_rdata <= 32'h0; n_recal <= 0;
    end else begin
      // Idle data toggles so a late sample cannot pass
      o_rdata <= ~o_rdata;
      if (i_rd) o_rdata <= (i_addr == 7'h00) ? {28'h0, mode_r, go_r} : (i_addr == 7'h40) ? {31'h0, ier_r} :
                           (i_addr == 7'h41) ? {31'h0, flag_r} : 32'h0;
      cnt_r <= go_r ? cnt_r + 8'h01 : 8'h00;
      // Go stays set until the running step ends
      if (go_r && (stp_r ? cnt_r >= STOP_LAT : mode_r == 3'h7 && cnt_r >= RECAL_LAT)) begin
        go_r <= 1'b0; stp_r <= 1'b0;
        if (!stp_r) n_recal <= n_recal + 1;
      end
      if (i_pkt) flag_r <= 1'b1;
      if (i_wr && i_addr == 7'h41 && i_wdata[0]) flag_r <= 1'b0;
      if (i_wr && i_addr == 7'h40) ier_r <= i_wdata[0];
      if (i_wr && i_addr == 7'h00) begin
        if (!go_r) mode_r <= i_wdata[3:1];
        if (i_wdata[0]) go_r <= 1'b1;
        else if (go_r) begin stp_r <= 1'b1; cnt_r <= 8'h00; end
      end
    end
  end
endmodule // asq_dev_model

// ===== test_asq_host_ctrl.sv
/* Testbench of the host controller against the device model.
   Assumes an op is taken at an edge with valid and ready high. */
`timescale 1ns/1ps
`include "asq_defs.vh"
module test_asq_host_ctrl;
  logic        i_core_clk, i_rst_n, i_op_valid, pkt;
  logic [3:0]  i_op;
  logic [31:0] res;
  int          n_mismatch, samples_checked, cyc, t0;
  wire         rdy, done, rd, wr, irq;
  wire  [6:0]  addr;
  wire  [31:0] wd, rdat, o_result;
  wire  [5:0]  st = {dev_i.ier_r, dev_i.flag_r, dev_i.mode_r, dev_i.go_r};
  // Rows: op, expected {ier, flag, mode, go}, mask
  localparam logic [0:8][15:0] ROWS = {{`ASQ_OP_IRQ_DIS, 6'h00, 6'h3f}, {`ASQ_OP_IRQ_EN, 6'h20, 6'h3f},
    {`ASQ_OP_MODE_SINGLE, 6'h22, 6'h3f}, {`ASQ_OP_START, 6'h23, 6'h3f}, {`ASQ_OP_STOP, 6'h22, 6'h3f},
    {`ASQ_OP_MODE_CONT, 6'h20, 6'h3f}, {`ASQ_OP_START, 6'h21, 6'h3f},
    {`ASQ_OP_MODE_SINGLE, 6'h22, 6'h3e}, {`ASQ_OP_RECAL, 6'h22, 6'h3e}};
  asq_host_ctrl asq_host_ctrl_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid),
    .i_op(i_op), .o_op_ready(rdy), .o_op_done(done), .o_result(o_result), .o_dev_read(rd),
    .o_dev_write(wr), .o_dev_addr(addr), .o_dev_wdata(wd), .i_dev_rdata(rdat));
  asq_dev_model dev_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rd(rd), .i_wr(wr), .i_addr(addr),
    .i_wdata(wd), .o_rdata(rdat), .i_pkt(pkt), .o_irq(irq));
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
  endtask
  task automatic chk_st(input logic [5:0] e, input logic [5:0] m);
    samples_checked++;
    if ((st & m) !== e) begin n_mismatch++; $display("MISMATCH state exp %h got %h", e, st & m); end
  endtask
  task automatic run_op(input logic [3:0] op);
    int n;
    n = 0;
    @(posedge i_core_clk) i_op <= op;
    i_op_valid <= 1'b1;
    do begin @(negedge i_core_clk); n++; end while (rdy !== 1'b1 && n < 500);
    @(posedge i_core_clk) i_op_valid <= 1'b0;
    do begin @(negedge i_core_clk); n++; end while (done !== 1'b1 && n < 2000);
    res = o_result;
    if (done !== 1'b1) begin n_mismatch++; $display("MISMATCH op_done exp 1 got %b", done); end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  // Hang guard: whole run needs well under this many cycles
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("MISMATCH cycle_limit exp below %0d got %0d", 20000, cyc);
      print_verdict();
    end
  end
  initial begin
    i_rst_n = 1'b0; i_op_valid = 1'b0; i_op = 4'h0; pkt = 1'b0;
    n_mismatch = 0; samples_checked = 0; cyc = 0;
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      run_op(ROWS[i][15:12]);
      chk_st(ROWS[i][11:6], ROWS[i][5:0]);
      $display("row %0d done", i);
    end
    chk_w("recal_count", 32'h1, dev_i.n_recal);
    fork begin repeat (40) @(posedge i_core_clk); pkt <= 1'b1; @(posedge i_core_clk) pkt <= 1'b0; end join_none
    t0 = cyc;
    run_op(`ASQ_OP_WAIT_PKT);
    chk_w("wait_after_pkt", 32'h1, 32'(cyc - t0 > 40));
    chk_w("irq", 32'h1, {31'h0, irq});
    run_op(`ASQ_OP_IRQ_DIS);
    chk_w("irq_masked", 32'h0, {31'h0, irq});
    run_op(`ASQ_OP_QUERY);
    chk_w("query_set", 32'hffffffff, res);
    run_op(`ASQ_OP_CLR_STATUS);
    chk_w("flag", 32'h0, {31'h0, dev_i.flag_r});
    run_op(`ASQ_OP_QUERY);
    chk_w("query_clear", 32'h0, res);
    $display("packet test done");
    run_op(`ASQ_OP_START);
    @(posedge i_core_clk) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(negedge i_core_clk);
    chk_st(6'h20, 6'h3f);
    chk_w("ready_after_reset", 32'h1, {31'h0, rdy});
    chk_w("idle_after_reset", 32'h0, {29'h0, rd, wr, done});
    chk_w("result_after_reset", 32'h0, o_result);
    run_op(`ASQ_OP_QUERY);
    chk_w("query_after_reset", 32'h0, res);
    $display("reset test done");
    print_verdict();
  end
endmodule // test_asq_host_ctrl
